// *** logic/fsk_reload_pkg.sv ***
`default_nettype none
package fsk_reload_pkg;

	localparam int COEF_W = 16;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	localparam int IDX_W  = 8;
	localparam int SLOT_W = 3;
	localparam int SLOTS  = 6;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_SPACE_AMP       = 8'h63;
	localparam logic [IDX_W-1:0] IDX_SPACE_FREQ      = 8'h64;
	localparam logic [IDX_W-1:0] IDX_MARK_AMP        = 8'h65;
	localparam logic [IDX_W-1:0] IDX_MARK_FREQ       = 8'h66;
	localparam logic [IDX_W-1:0] IDX_SPACE_MARK_GAIN = 8'h67;
	localparam logic [IDX_W-1:0] IDX_MARK_SPACE_GAIN = 8'h68;
	localparam logic [IDX_W-1:0] IDX_SHIFT_CTRL      = 8'h6c;
	localparam logic [IDX_W-1:0] IDX_RELOAD_CTRL     = 8'h20;
	localparam logic [IDX_W-1:0] IDX_TONE1_AMP       = 8'h70;
	localparam logic [IDX_W-1:0] IDX_TONE1_FREQ      = 8'h71;
	localparam logic [IDX_W-1:0] IDX_TONE1_TIMER     = 8'h72;
	localparam logic [IDX_W-1:0] IDX_TX_BIT          = 8'h73;
	localparam logic [IDX_W-1:0] IDX_STATUS          = 8'h74;

	// coefficient store slots
	localparam logic [SLOT_W-1:0] SLOT_SPACE_AMP  = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_SPACE_FREQ = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_MARK_AMP   = 3'h2;
	localparam logic [SLOT_W-1:0] SLOT_MARK_FREQ  = 3'h3;
	localparam logic [SLOT_W-1:0] SLOT_S2M_GAIN   = 3'h4;
	localparam logic [SLOT_W-1:0] SLOT_M2S_GAIN   = 3'h5;

	// field positions
	localparam int SHIFT_EN_BIT  = 6;
	localparam int RELOAD_EN_BIT = 6;
	localparam int TX_BIT_POS    = 0;
	localparam int STAT_MODE_BIT = 0;
	localparam int STAT_LAST_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	// reset values
	localparam logic [COEF_W-1:0] COEF_RST   = 16'h0000;
	localparam logic [COEF_W-1:0] TIMER_RST  = 16'h0000;
	localparam logic              EN_RST     = 1'b0;
	localparam logic              TX_BIT_RST = 1'b1;

	// gain factors are unsigned with this many fraction bits
	localparam int GAIN_FRAC = 14;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_AMP  = 3'h1,
		ST_FRQ  = 3'h2,
		ST_GAIN = 3'h3,
		ST_MUL  = 3'h4,
		ST_LOAD = 3'h5
	} reload_state_t;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'h0,
		BUS_FETCH  = 2'h1,
		BUS_ANSWER = 2'h2
	} bus_state_t;

	function automatic logic is_slot(input logic [IDX_W-1:0] idx);
		is_slot = (idx >= IDX_SPACE_AMP) && (idx <= IDX_MARK_SPACE_GAIN);
	endfunction

	function automatic logic [SLOT_W-1:0] slot_of(input logic [IDX_W-1:0] idx);
		logic [IDX_W-1:0] diff;
		diff = idx - IDX_SPACE_AMP;
		slot_of = diff[SLOT_W-1:0];
	endfunction

	// saturates instead of wrapping so a large factor cannot fold the tone
	function automatic logic [COEF_W-1:0] gain_scale(input logic [COEF_W-1:0] amp,
		input logic [COEF_W-1:0] gain);
		logic [2*COEF_W-1:0] prod;
		logic [2*COEF_W-1:0] shifted;
		prod = {{COEF_W{1'b0}}, amp} * {{COEF_W{1'b0}}, gain};
		shifted = prod >> GAIN_FRAC;
		gain_scale = (|shifted[2*COEF_W-1:COEF_W]) ? {COEF_W{1'b1}} : shifted[COEF_W-1:0];
	endfunction

endpackage
`default_nettype wire

// *** logic/coef_store.sv ***
`timescale 1ns/1ns
`default_nettype none
module coef_store #(
	parameter int W     = 16,
	parameter int DEPTH = 6,
	parameter int AW    = 3
) (
	input  wire logic          mclk,
	input  wire logic          rst_b,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W/8-1:0] wr_be,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr_a,
	output logic      [W-1:0]  rd_data_a,
	input  wire logic [AW-1:0] rd_addr_b,
	output logic      [W-1:0]  rd_data_b
);
	import fsk_reload_pkg::*;

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] rd_a_q;
	logic [W-1:0] rd_b_q;

	for (genvar g = 0; g < DEPTH; g++) begin : g_word
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				mem_q[g] <= W'(COEF_RST);
			end else if (wr_en && (wr_addr == AW'(g))) begin
				for (int b = 0; b < W/8; b++) begin
					if (wr_be[b]) begin
						mem_q[g][b*8 +: 8] <= wr_data[b*8 +: 8];
					end
				end
			end
		end
	end

	// two registered read ports: one for the bus, one for the reload engine
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_a_q <= '0;
			rd_b_q <= '0;
		end else begin
			rd_a_q <= (int'(rd_addr_a) < DEPTH) ? mem_q[rd_addr_a] : '0;
			rd_b_q <= (int'(rd_addr_b) < DEPTH) ? mem_q[rd_addr_b] : '0;
		end
	end

	assign rd_data_a = rd_a_q;
	assign rd_data_b = rd_b_q;
endmodule
`default_nettype wire

// *** logic/gain_apply.sv ***
`timescale 1ns/1ns
`default_nettype none
module gain_apply (
	input  wire logic [fsk_reload_pkg::COEF_W-1:0] amp,
	input  wire logic [fsk_reload_pkg::COEF_W-1:0] gain,
	input  wire logic                              mclk,
	input  wire logic                              rst_b,
	output logic      [fsk_reload_pkg::COEF_W-1:0] scaled
);
	import fsk_reload_pkg::*;

	logic [COEF_W-1:0] scaled_q;

	// registered so the wide product does not sit in the load path
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			scaled_q <= COEF_RST;
		end else begin
			scaled_q <= gain_scale(amp, gain);
		end
	end

	assign scaled = scaled_q;
endmodule
`default_nettype wire

// *** logic/fsk_caller_id_oscillator_reload.sv ***
// Functional notes
// - enhanced mode only when both enables set
// - space expiry loads space amplitude coefficient
// - space expiry loads space frequency coefficient
// - mark expiry loads mark amplitude coefficient
// - mark expiry loads mark frequency coefficient
// - space-to-mark change scales amplitude by gain
// - mark-to-space change scales amplitude by gain
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module fsk_caller_id_oscillator_reload (
	input  wire logic                              mclk,
	input  wire logic                              rst_b,
	input  wire logic [fsk_reload_pkg::ADDR_W-1:0] address,
	input  wire logic                              read,
	input  wire logic                              write,
	input  wire logic [fsk_reload_pkg::DATA_W-1:0] writedata,
	input  wire logic [fsk_reload_pkg::BE_W-1:0]   byteenable,
	output logic      [fsk_reload_pkg::DATA_W-1:0] readdata,
	output logic                                   waitrequest,
	output logic      [fsk_reload_pkg::COEF_W-1:0] tone1_amp,
	output logic      [fsk_reload_pkg::COEF_W-1:0] tone1_freq,
	output logic                                   tone1_reload,
	output logic                                   fsk_mode
);
	import fsk_reload_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	bus_state_t          bus_st_q;
	logic                waitrequest_q;
	logic [DATA_W-1:0]   readdata_q;
	logic [DATA_W-1:0]   read_mux;
	logic [IDX_W-1:0]    idx;
	logic                commit_wr;

	logic                shift_en_q;
	logic                reload_en_q;
	logic                tx_bit_q;
	logic [COEF_W-1:0]   norm_amp_q;
	logic [COEF_W-1:0]   norm_freq_q;
	logic [COEF_W-1:0]   timer_q;
	logic [COEF_W-1:0]   tmr_cnt_q;

	reload_state_t       st_q;
	logic                bit_q;
	logic                trans_q;
	logic                last_bit_q;
	logic [COEF_W-1:0]   amp_q;
	logic [COEF_W-1:0]   freq_q;
	logic [SLOT_W-1:0]   addr_b;
	logic [COEF_W-1:0]   rd_a;
	logic [COEF_W-1:0]   rd_b;
	logic [COEF_W-1:0]   scaled;

	logic [COEF_W-1:0]   tone1_amp_q;
	logic [COEF_W-1:0]   tone1_freq_q;
	logic                tone1_reload_q;
	logic                fsk_mode_q;

	logic                mode_on;
	logic                expire;
	logic                start_fsk;
	logic                start_norm;

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: every access holds waitrequest for two cycles so the
	// registered coefficient store can answer reads

	assign idx       = address[ADDR_W-1:2];
	assign commit_wr = write && (bus_st_q == BUS_ANSWER);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bus_st_q      <= BUS_IDLE;
			waitrequest_q <= 1'b1;
			readdata_q    <= '0;
		end else begin
			case (bus_st_q)
				BUS_IDLE: begin
					if (read || write) begin
						bus_st_q <= BUS_FETCH;
					end
				end
				BUS_FETCH: begin
					bus_st_q      <= BUS_ANSWER;
					waitrequest_q <= 1'b0;
					readdata_q    <= read ? read_mux : '0;
				end
				BUS_ANSWER: begin
					bus_st_q      <= BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
				default: begin
					bus_st_q      <= BUS_IDLE;
					waitrequest_q <= 1'b1;
				end
			endcase
		end
	end

	// unmapped indices read as zero and ignore writes
	always_comb begin
		read_mux = '0;
		if (is_slot(idx)) begin
			read_mux[COEF_W-1:0] = rd_a;
		end else begin
			case (idx)
				IDX_SHIFT_CTRL:  read_mux[SHIFT_EN_BIT]  = shift_en_q;
				IDX_RELOAD_CTRL: read_mux[RELOAD_EN_BIT] = reload_en_q;
				IDX_TONE1_AMP:   read_mux[COEF_W-1:0]    = norm_amp_q;
				IDX_TONE1_FREQ:  read_mux[COEF_W-1:0]    = norm_freq_q;
				IDX_TONE1_TIMER: read_mux[COEF_W-1:0]    = timer_q;
				IDX_TX_BIT:      read_mux[TX_BIT_POS]    = tx_bit_q;
				IDX_STATUS: begin
					read_mux[STAT_MODE_BIT] = mode_on;
					read_mux[STAT_LAST_BIT] = last_bit_q;
					read_mux[STAT_BUSY_BIT] = (st_q != ST_IDLE);
				end
				default: read_mux = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control bits

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			shift_en_q  <= EN_RST;
			reload_en_q <= EN_RST;
		end else if (commit_wr && byteenable[0]) begin
			if (idx == IDX_SHIFT_CTRL) begin
				shift_en_q <= writedata[SHIFT_EN_BIT];
			end
			if (idx == IDX_RELOAD_CTRL) begin
				reload_en_q <= writedata[RELOAD_EN_BIT];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tx_bit_q <= TX_BIT_RST;
		end else if (commit_wr && byteenable[0] && (idx == IDX_TX_BIT)) begin
			tx_bit_q <= writedata[TX_BIT_POS];
		end
	end

	// ordinary tone 1 coefficients and the active timer period
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			norm_amp_q  <= COEF_RST;
			norm_freq_q <= COEF_RST;
			timer_q     <= TIMER_RST;
		end else if (commit_wr) begin
			for (int b = 0; b < COEF_W/8; b++) begin
				if (byteenable[b]) begin
					case (idx)
						IDX_TONE1_AMP:   norm_amp_q[b*8 +: 8]  <= writedata[b*8 +: 8];
						IDX_TONE1_FREQ:  norm_freq_q[b*8 +: 8] <= writedata[b*8 +: 8];
						IDX_TONE1_TIMER: timer_q[b*8 +: 8]     <= writedata[b*8 +: 8];
						default: ;
					endcase
				end
			end
		end
	end

	coef_store #(
		.W     (COEF_W),
		.DEPTH (SLOTS),
		.AW    (SLOT_W)
	) u_store (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.wr_en     (commit_wr && is_slot(idx)),
		.wr_addr   (slot_of(idx)),
		.wr_be     (byteenable[COEF_W/8-1:0]),
		.wr_data   (writedata[COEF_W-1:0]),
		.rd_addr_a (slot_of(idx)),
		.rd_data_a (rd_a),
		.rd_addr_b (addr_b),
		.rd_data_b (rd_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	// active timer: a zero period keeps the oscillator from reloading

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tmr_cnt_q <= TIMER_RST;
		end else if (timer_q == '0) begin
			tmr_cnt_q <= '0;
		end else if (tmr_cnt_q == '0) begin
			tmr_cnt_q <= timer_q - 16'h0001;
		end else begin
			tmr_cnt_q <= tmr_cnt_q - 16'h0001;
		end
	end

	assign expire  = (timer_q != '0) && (tmr_cnt_q == '0);
	assign mode_on = shift_en_q && reload_en_q;
	// an expiry while a reload is still in flight is dropped; periods below
	// six cycles therefore cannot sustain the enhanced sequence
	assign start_fsk  = expire && mode_on && (st_q == ST_IDLE);
	assign start_norm = expire && !mode_on && (st_q == ST_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// enhanced reload engine: fetch amplitude, frequency and gain in turn

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q    <= ST_IDLE;
			bit_q   <= TX_BIT_RST;
			trans_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start_fsk) begin
						st_q    <= ST_AMP;
						bit_q   <= tx_bit_q;
						trans_q <= tx_bit_q != last_bit_q;
					end
				end
				ST_AMP:  st_q <= ST_FRQ;
				ST_FRQ:  st_q <= ST_GAIN;
				ST_GAIN: st_q <= ST_MUL;
				ST_MUL:  st_q <= ST_LOAD;
				ST_LOAD: st_q <= ST_IDLE;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		case (st_q)
			ST_AMP:  addr_b = bit_q ? SLOT_MARK_AMP : SLOT_SPACE_AMP;
			ST_FRQ:  addr_b = bit_q ? SLOT_MARK_FREQ : SLOT_SPACE_FREQ;
			ST_GAIN: addr_b = bit_q ? SLOT_S2M_GAIN : SLOT_M2S_GAIN;
			default: addr_b = SLOT_SPACE_AMP;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			amp_q  <= COEF_RST;
			freq_q <= COEF_RST;
		end else begin
			if (st_q == ST_FRQ) begin
				amp_q <= rd_b;
			end
			if (st_q == ST_GAIN) begin
				freq_q <= rd_b;
			end
		end
	end

	gain_apply u_gain (
		.amp    (amp_q),
		.gain   (rd_b),
		.mclk   (mclk),
		.rst_b  (rst_b),
		.scaled (scaled)
	);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			last_bit_q <= TX_BIT_RST;
		end else if (st_q == ST_LOAD) begin
			last_bit_q <= bit_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator 1 coefficient outputs

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tone1_amp_q    <= COEF_RST;
			tone1_freq_q   <= COEF_RST;
			tone1_reload_q <= 1'b0;
		end else if (start_norm) begin
			tone1_amp_q    <= norm_amp_q;
			tone1_freq_q   <= norm_freq_q;
			tone1_reload_q <= 1'b1;
		end else if (st_q == ST_LOAD) begin
			tone1_amp_q    <= trans_q ? scaled : amp_q;
			tone1_freq_q   <= freq_q;
			tone1_reload_q <= 1'b1;
		end else begin
			tone1_reload_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fsk_mode_q <= 1'b0;
		end else begin
			fsk_mode_q <= mode_on;
		end
	end

	assign readdata     = readdata_q;
	assign waitrequest  = waitrequest_q;
	assign tone1_amp    = tone1_amp_q;
	assign tone1_freq   = tone1_freq_q;
	assign tone1_reload = tone1_reload_q;
	assign fsk_mode     = fsk_mode_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_mode_select;
		@(posedge mclk) disable iff (!rst_b)
		(expire && st_q == ST_IDLE) |=> ((st_q != ST_IDLE) == $past(shift_en_q && reload_en_q));
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("enhanced mode taken without both enables");

	property p_space_amp;
		@(posedge mclk) disable iff (!rst_b)
		(start_fsk && !tx_bit_q && !last_bit_q) |-> ##6
		(tone1_reload_q && tone1_amp_q == $past(rd_b, 4) && $past(addr_b, 5) == SLOT_SPACE_AMP);
	endproperty
	a_space_amp: assert property (p_space_amp) else $error("space amplitude not loaded");

	property p_space_freq;
		@(posedge mclk) disable iff (!rst_b)
		(start_fsk && !tx_bit_q) |-> ##6
		(tone1_freq_q == $past(rd_b, 3) && $past(addr_b, 4) == SLOT_SPACE_FREQ);
	endproperty
	a_space_freq: assert property (p_space_freq) else $error("space frequency not loaded");

	property p_mark_amp;
		@(posedge mclk) disable iff (!rst_b)
		(start_fsk && tx_bit_q && last_bit_q) |-> ##6
		(tone1_reload_q && tone1_amp_q == $past(rd_b, 4) && $past(addr_b, 5) == SLOT_MARK_AMP);
	endproperty
	a_mark_amp: assert property (p_mark_amp) else $error("mark amplitude not loaded");

	property p_mark_freq;
		@(posedge mclk) disable iff (!rst_b)
		(start_fsk && tx_bit_q) |-> ##6
		(tone1_freq_q == $past(rd_b, 3) && $past(addr_b, 4) == SLOT_MARK_FREQ);
	endproperty
	a_mark_freq: assert property (p_mark_freq) else $error("mark frequency not loaded");

	property p_space_to_mark;
		@(posedge mclk) disable iff (!rst_b)
		(start_fsk && tx_bit_q && !last_bit_q) |-> ##6
		(tone1_amp_q == gain_scale($past(rd_b, 4), $past(rd_b, 2)) && $past(addr_b, 3) == SLOT_S2M_GAIN
		&& $past(addr_b, 5) == SLOT_MARK_AMP);
	endproperty
	a_space_to_mark: assert property (p_space_to_mark) else $error("space to mark gain not applied");

	property p_mark_to_space;
		@(posedge mclk) disable iff (!rst_b)
		(start_fsk && !tx_bit_q && last_bit_q) |-> ##6
		(tone1_amp_q == gain_scale($past(rd_b, 4), $past(rd_b, 2)) && $past(addr_b, 3) == SLOT_M2S_GAIN
		&& $past(addr_b, 5) == SLOT_SPACE_AMP);
	endproperty
	a_mark_to_space: assert property (p_mark_to_space) else $error("mark to space gain not applied");

	property p_normal_reload;
		@(posedge mclk) disable iff (!rst_b)
		(expire && !(shift_en_q && reload_en_q) && st_q == ST_IDLE) |=>
		(tone1_reload_q && tone1_amp_q == $past(norm_amp_q) && tone1_freq_q == $past(norm_freq_q)
		&& st_q == ST_IDLE);
	endproperty
	a_normal_reload: assert property (p_normal_reload) else $error("normal coefficients not reloaded");

endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin num_errors++; $display("wrong value at %0t ns: %s", $time, msg); end end
module testbench;
	import fsk_reload_pkg::*;

	logic                mclk;
	logic                rst_b;
	logic [ADDR_W-1:0]   address;
	logic                read;
	logic                write;
	logic [DATA_W-1:0]   writedata;
	logic [BE_W-1:0]     byteenable;
	logic [DATA_W-1:0]   readdata;
	logic                waitrequest;
	logic [COEF_W-1:0]   tone1_amp;
	logic [COEF_W-1:0]   tone1_freq;
	logic                tone1_reload;
	logic                fsk_mode;
	int                  num_errors;
	int                  total_checks;
	logic [DATA_W-1:0]   rd;

	// coefficient values chosen so the gain products come out exact
	localparam logic [COEF_W-1:0] SP_AMP = 16'h0800;
	localparam logic [COEF_W-1:0] SP_FRQ = 16'h0321;
	localparam logic [COEF_W-1:0] MK_AMP = 16'h1000;
	localparam logic [COEF_W-1:0] MK_FRQ = 16'h0654;
	localparam logic [COEF_W-1:0] S2M    = 16'h6000;
	localparam logic [COEF_W-1:0] M2S    = 16'h2000;
	localparam logic [COEF_W-1:0] N_AMP  = 16'h1234;
	localparam logic [COEF_W-1:0] N_FRQ  = 16'h0abc;
	logic [COEF_W-1:0] coef_tbl [SLOTS] = '{SP_AMP, SP_FRQ, MK_AMP, MK_FRQ, S2M, M2S};

	fsk_caller_id_oscillator_reload i_dut (
		.mclk         (mclk),
		.rst_b        (rst_b),
		.address      (address),
		.read         (read),
		.write        (write),
		.writedata    (writedata),
		.byteenable   (byteenable),
		.readdata     (readdata),
		.waitrequest  (waitrequest),
		.tone1_amp    (tone1_amp),
		.tone1_freq   (tone1_freq),
		.tone1_reload (tone1_reload),
		.fsk_mode     (fsk_mode)
	);

	always #5 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////////////
	// one avalon transfer; the request stands until waitrequest is sampled low
	task automatic bus(input logic we, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data,
		input logic [BE_W-1:0] be, output logic [DATA_W-1:0] rdata);
		int n;
		n = 0;
		@(posedge mclk);
		address    <= {idx, 2'b00};
		writedata  <= data;
		byteenable <= be;
		write      <= we;
		read       <= ~we;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rdata = readdata;
		if (n >= 50) begin
			num_errors++;
			$display("wrong value at %0t ns: bus handshake never completed", $time);
		end
		write <= 1'b0;
		read  <= 1'b0;
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data);
		logic [DATA_W-1:0] dummy;
		bus(1'b1, idx, data, 4'hf, dummy);
	endtask

	// waits for up to three loads until the frequency shows the wanted one; stale loads may precede it
	task automatic wait_load(input logic [COEF_W-1:0] frq);
		int n;
		int k;
		for (k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (tone1_reload !== 1'b1 && n < 200);
			if (tone1_freq === frq || n >= 200) begin
				break;
			end
		end
		`CHK(tone1_freq, frq, "frequency loaded into tone 1")
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_registers();
		int i;
		for (i = 0; i < SLOTS; i++) begin
			wr(IDX_SPACE_AMP + i[IDX_W-1:0], {16'h0000, coef_tbl[i]});
		end
		for (i = 0; i < SLOTS; i++) begin
			bus(1'b0, IDX_SPACE_AMP + i[IDX_W-1:0], 32'h0, 4'hf, rd);
			`CHK(rd, {16'h0000, coef_tbl[i]}, "coefficient read back")
		end
		// only lane 0 may change
		bus(1'b1, IDX_MARK_SPACE_GAIN, 32'h0000ffff, 4'h1, rd);
		bus(1'b0, IDX_MARK_SPACE_GAIN, 32'h0, 4'hf, rd);
		`CHK(rd, {16'h0000, M2S[15:8], 8'hff}, "byte lane write")
		wr(IDX_MARK_SPACE_GAIN, {16'h0000, M2S});
		wr(8'h10, 32'h0000beef);
		bus(1'b0, 8'h10, 32'h0, 4'hf, rd);
		`CHK(rd, 32'h00000000, "unmapped index reads zero")
	endtask

	task automatic t_normal();
		wr(IDX_TONE1_AMP, {16'h0000, N_AMP});
		wr(IDX_TONE1_FREQ, {16'h0000, N_FRQ});
		wr(IDX_RELOAD_CTRL, 32'h00000040);
		wr(IDX_TONE1_TIMER, 32'h00000014);
		wait_load(N_FRQ);
		`CHK(tone1_amp, N_AMP, "normal amplitude with one enable")
		`CHK(fsk_mode, 1'b0, "mode off with one enable")
		bus(1'b0, IDX_RELOAD_CTRL, 32'h0, 4'hf, rd);
		`CHK(rd, 32'h00000040, "reload enable reads back")
	endtask

	task automatic t_enhanced();
		wr(IDX_SHIFT_CTRL, 32'h00000040);
		repeat (3) @(posedge mclk);
		`CHK(fsk_mode, 1'b1, "mode on with both enables")
		wait_load(MK_FRQ);
		`CHK(tone1_amp, MK_AMP, "mark amplitude, no transition")
		wr(IDX_TX_BIT, 32'h00000000);
		wait_load(SP_FRQ);
		`CHK(tone1_amp, 16'h0400, "space amplitude scaled by mark-to-space gain")
		wait_load(SP_FRQ);
		`CHK(tone1_amp, SP_AMP, "space amplitude, no transition")
		wr(IDX_TX_BIT, 32'h00000001);
		wait_load(MK_FRQ);
		`CHK(tone1_amp, 16'h1800, "mark amplitude scaled by space-to-mark gain")
		// read lands well before the next expiry, so the engine is idle
		bus(1'b0, IDX_STATUS, 32'h0, 4'hf, rd);
		`CHK(rd, 32'h00000003, "status: mode on, mark sent last, idle")
	endtask

	task automatic t_disable();
		wr(IDX_RELOAD_CTRL, 32'h00000000);
		wait_load(N_FRQ);
		`CHK(tone1_amp, N_AMP, "normal amplitude after reload enable cleared")
		`CHK(fsk_mode, 1'b0, "mode off after reload enable cleared")
		bus(1'b0, IDX_STATUS, 32'h0, 4'hf, rd);
		`CHK(rd, 32'h00000002, "status: mode off, mark sent last, idle")
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (num_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		mclk         = 1'b0;
		rst_b        = 1'b0;
		address      = '0;
		read         = 1'b0;
		write        = 1'b0;
		writedata    = '0;
		byteenable   = '0;
		num_errors   = 0;
		total_checks = 0;
		repeat (3) @(posedge mclk);
		`CHK(waitrequest, 1'b1, "waitrequest during reset")
		`CHK(tone1_reload, 1'b0, "reload pulse during reset")
		rst_b <= 1'b1;
		@(posedge mclk);
		t_registers();
		t_normal();
		t_enhanced();
		t_disable();
		print_verdict();
	end

	// the whole sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		print_verdict();
	end

endmodule
`default_nettype wire
